// ==== fwpc_pkg.sv ====
// constants for the fifo / waveform pin configuration block
package fwpc_pkg;

    // interface mode field, interfaceConfig[1:0]
    localparam logic [1:0] FWPC_MODE_PORTS    = 2'h0;
    localparam logic [1:0] FWPC_MODE_RESERVED = 2'h1;
    localparam logic [1:0] FWPC_MODE_WAVEFORM = 2'h2;
    localparam logic [1:0] FWPC_MODE_FIFO     = 2'h3;
    localparam int FWPC_CFG_MODE_LSB = 0;
    localparam int FWPC_CFG_MODE_MSB = 1;

    // interface configuration bit positions
    localparam int FWPC_CFG_INV_BIT    = 4;
    localparam int FWPC_CFG_FREQ_BIT   = 5;
    localparam int FWPC_CFG_CLKOE_BIT  = 6;
    localparam int FWPC_CFG_INTCLK_BIT = 7;

    // fifo pin polarity bit positions
    localparam int FWPC_POL_WR_BIT = 2;
    localparam int FWPC_POL_RD_BIT = 3;

    // pin counts
    localparam int FWPC_NUM_READY  = 6;
    localparam int FWPC_NUM_CTRL   = 6;
    localparam int FWPC_NUM_FIFOS  = 4;
    localparam int FWPC_NUM_FLAGS  = 3;
    localparam int FWPC_SEL_W      = 2;
    localparam int FWPC_SYNC_W     = 11;

    // sync vector layout
    localparam int FWPC_SY_READY_LSB = 0;
    localparam int FWPC_SY_IRQ4      = 6;
    localparam int FWPC_SY_IRQ5N     = 7;
    localparam int FWPC_SY_SEL_LSB   = 8;
    localparam int FWPC_SY_IFACE_CLK = 10;
    // irq5 pin idles high, all others idle low
    localparam logic [10:0] FWPC_SYNC_RST = 11'h080;

    // reset values of pins
    localparam logic [5:0] FWPC_CTRL_RST = 6'h3F;

    // internal interface clock: core clock 20 ns, half periods in core cycles
    localparam int FWPC_CORE_PERIOD_NS = 20;
    localparam int FWPC_HALF_FAST_NS   = 20;
    localparam int FWPC_HALF_SLOW_NS   = 40;
    localparam logic [2:0] FWPC_HALF_FAST =
        3'((FWPC_HALF_FAST_NS + FWPC_CORE_PERIOD_NS - 1) / FWPC_CORE_PERIOD_NS);
    localparam logic [2:0] FWPC_HALF_SLOW =
        3'((FWPC_HALF_SLOW_NS + FWPC_CORE_PERIOD_NS - 1) / FWPC_CORE_PERIOD_NS);

endpackage : fwpc_pkg

// ==== fwpc_sync3.sv ====
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module fwpc_sync3
    import fwpc_pkg::*;
#(
    parameter int          WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] levelOut
);
    logic [WIDTH-1:0] stage1Reg;
    logic [WIDTH-1:0] stage2Reg;
    logic [WIDTH-1:0] stage3Reg;

    // shift chain; stage one feeds only stage two
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            stage1Reg <= RST_VAL;
            stage2Reg <= RST_VAL;
            stage3Reg <= RST_VAL;
        end else begin
            stage1Reg <= pinIn;
            stage2Reg <= stage1Reg;
            stage3Reg <= stage2Reg;
        end
    end

    // a change is accepted once stages two and three agree
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_agree
            always_ff @(posedge clock) begin
                if (!rst_n) begin
                    levelOut[i] <= RST_VAL[i];
                end else if (stage2Reg[i] == stage3Reg[i]) begin
                    levelOut[i] <= stage3Reg[i];
                end
            end
        end
    endgenerate
endmodule : fwpc_sync3

// ==== fwpc_clk_div.sv ====
// divider that makes the internally sourced interface clock
`timescale 1ns/1ps
module fwpc_clk_div
    import fwpc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic fastSel,
    output logic      clkOut
);
    logic [2:0] countReg;
    logic [2:0] halfLen;

    assign halfLen = fastSel ? FWPC_HALF_FAST : FWPC_HALF_SLOW;

    // toggle every half period while enabled, park low otherwise
    always_ff @(posedge clock) begin
        if (!rst_n || !enable) begin
            countReg <= 3'h0;
            clkOut   <= 1'b0;
        end else if (countReg >= halfLen - 3'h1) begin
            countReg <= 3'h0;
            clkOut   <= ~clkOut;
        end else begin
            countReg <= countReg + 3'h1;
        end
    end
endmodule : fwpc_clk_div

// ==== fwpc_pin_config.sv ====
// pin multiplexer for the waveform engine and slave fifo interface pins
`timescale 1ns/1ps
module fwpc_pin_config
    import fwpc_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    // configuration
    input  wire logic [7:0]                interfaceConfig,
    input  wire logic [7:0]                fifoPinPolarity,
    // device pins
    input  wire logic [FWPC_NUM_READY-1:0] readyInPins,
    output logic      [FWPC_NUM_CTRL-1:0]  ctrlOutPins,
    input  wire logic [FWPC_SEL_W-1:0]     fifoSelectPins,
    input  wire logic                      interfaceClockIn,
    output logic                           interfaceClockOut,
    output logic                           interfaceClockOe,
    input  wire logic                      extIrqFour,
    input  wire logic                      extIrqFiveN,
    // waveform engine side
    input  wire logic [FWPC_NUM_CTRL-1:0]  waveformCtrl,
    output logic      [FWPC_NUM_READY-1:0] waveformReady,
    // slave fifo side
    input  wire logic [FWPC_NUM_FIFOS-1:0] fifoProgLevel,
    input  wire logic [FWPC_NUM_FIFOS-1:0] fifoFull,
    input  wire logic [FWPC_NUM_FIFOS-1:0] fifoEmpty,
    output logic      [FWPC_SEL_W-1:0]     fifoSelect,
    output logic                           fifoReadPulse,
    output logic                           fifoWritePulse,
    // timing and interrupt events
    output logic                           interfaceClockTick,
    output logic                           irqFourReq,
    output logic                           irqFiveReq
);

    typedef enum logic [1:0] {
        FWPC_ROUTE_PORTS,
        FWPC_ROUTE_ENGINE,
        FWPC_ROUTE_FIFO
    } fwpc_route_type;

    // picks one fifo's condition by the select lines
    function automatic logic fwpcPick(
        input logic [FWPC_NUM_FIFOS-1:0] cond,
        input logic [FWPC_SEL_W-1:0]     sel
    );
        fwpcPick = cond[sel];
    endfunction : fwpcPick

    // true when a strobe level matches its programmed active level
    function automatic logic fwpcActive(
        input logic level,
        input logic activeHigh
    );
        fwpcActive = (level == activeHigh);
    endfunction : fwpcActive

    // routing of the shared pins
    fwpc_route_type            route;
    logic                      fifoRoute;

    // synchronised pin levels
    logic [FWPC_SYNC_W-1:0]    syncIn;
    logic [FWPC_SYNC_W-1:0]    syncLevel;
    logic [FWPC_NUM_READY-1:0] readyLevel;
    logic [FWPC_SEL_W-1:0]     selLevel;
    logic                      irqFourLevel;
    logic                      irqFiveNLevel;
    logic                      extClkLevel;

    // interface clock source and edge history
    logic                      intClk;
    logic                      intClkSel;
    logic                      invertClk;
    logic                      rawClk;
    logic                      effClk;
    logic                      effClkPrev_reg;
    logic                      tick;

    // interrupt pin history
    logic                      irqFourPrev_reg;
    logic                      irqFiveNPrev_reg;

    // strobes and shared outputs
    logic                      readActive;
    logic                      writeActive;
    logic [FWPC_NUM_FIFOS-1:0] flagCond [FWPC_NUM_FLAGS];
    logic [FWPC_NUM_FLAGS-1:0] flagPin_next;
    logic [FWPC_NUM_CTRL-1:0]  ctrlOut_next;

    // decode the mode field into a pin route
    always_comb begin
        case (interfaceConfig[FWPC_CFG_MODE_MSB:FWPC_CFG_MODE_LSB])
            FWPC_MODE_WAVEFORM: route = FWPC_ROUTE_ENGINE;
            FWPC_MODE_FIFO:     route = FWPC_ROUTE_FIFO;
            default:            route = FWPC_ROUTE_PORTS;
        endcase
    end

    // gather every asynchronous pin into one synchroniser
    assign syncIn = {interfaceClockIn, fifoSelectPins, extIrqFiveN, extIrqFour, readyInPins};

    // three-stage filter on every asynchronous pin
    fwpc_sync3 #(
        .WIDTH   (FWPC_SYNC_W),
        .RST_VAL (FWPC_SYNC_RST)
    ) u_sync (
        .clock    (clock),
        .rst_n    (rst_n),
        .pinIn    (syncIn),
        .levelOut (syncLevel)
    );

    // slices of the synchronised pin vector
    assign readyLevel    = syncLevel[FWPC_SY_READY_LSB +: FWPC_NUM_READY];
    assign irqFourLevel  = syncLevel[FWPC_SY_IRQ4];
    assign irqFiveNLevel = syncLevel[FWPC_SY_IRQ5N];
    assign selLevel      = syncLevel[FWPC_SY_SEL_LSB +: FWPC_SEL_W];
    assign extClkLevel   = syncLevel[FWPC_SY_IFACE_CLK];

    // the fifo route also gates the strobes, flags and shared ready bits
    assign fifoRoute = (route == FWPC_ROUTE_FIFO);

    // interface clock source selection
    assign intClk    = interfaceConfig[FWPC_CFG_INTCLK_BIT];
    assign intClkSel = interfaceConfig[FWPC_CFG_FREQ_BIT];
    assign invertClk = interfaceConfig[FWPC_CFG_INV_BIT];

    // divider for the internally sourced clock
    fwpc_clk_div u_clk_div (
        .clock   (clock),
        .rst_n   (rst_n),
        .enable  (intClk),
        .fastSel (intClkSel),
        .clkOut  (rawClk)
    );

    // effective clock: chosen source, optionally inverted
    assign effClk = (intClk ? rawClk : extClkLevel) ^ invertClk;

    // rising edge of the effective clock, one core cycle wide
    assign tick   = effClk & ~effClkPrev_reg;

    // last level of the effective interface clock
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            effClkPrev_reg <= invertClk; // idle level of the clock, so no false edge
        end else begin
            effClkPrev_reg <= effClk;
        end
    end

    // registered tick for the rest of the device
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            interfaceClockTick <= 1'b0;
        end else begin
            interfaceClockTick <= tick;
        end
    end

    // clock pin level: divider output with the optional inversion
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            interfaceClockOut <= 1'b0;
        end else begin
            interfaceClockOut <= rawClk ^ invertClk;
        end
    end

    // drive the clock pin only when sourced inside with its output enable bit set, otherwise float it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            interfaceClockOe <= 1'b0;
        end else begin
            interfaceClockOe <= intClk & interfaceConfig[FWPC_CFG_CLKOE_BIT];
        end
    end

    // strobes compared against their programmed active level
    assign readActive  = fwpcActive(readyLevel[0], fifoPinPolarity[FWPC_POL_RD_BIT]);
    assign writeActive = fwpcActive(readyLevel[1], fifoPinPolarity[FWPC_POL_WR_BIT]);

    // one read pulse per interface clock edge while the strobe is held active
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fifoReadPulse <= 1'b0;
        end else begin
            fifoReadPulse <= fifoRoute && tick && readActive;
        end
    end

    // one write pulse per interface clock edge while the strobe is held active
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fifoWritePulse <= 1'b0;
        end else begin
            fifoWritePulse <= fifoRoute && tick && writeActive;
        end
    end

    // fifo address latched on the interface clock
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            fifoSelect <= '0;
        end else if (tick) begin
            fifoSelect <= selLevel;
        end
    end

    // ready inputs reach the engine unless the fifo owns them
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            waveformReady <= '0;
        end else if (fifoRoute) begin
            waveformReady <= {readyLevel[FWPC_NUM_READY-1:2], 2'h0};
        end else begin
            waveformReady <= readyLevel;
        end
    end

    // flag conditions of every fifo, in pin order
    assign flagCond = '{fifoProgLevel, fifoFull, fifoEmpty};

    // a flag is low on its pin while the selected fifo meets its condition
    genvar f;
    generate
        for (f = 0; f < FWPC_NUM_FLAGS; f++) begin : g_flag
            assign flagPin_next[f] = ~fwpcPick(flagCond[f], selLevel);
        end
    endgenerate

    // shared outputs: engine controls or low-active fifo flags
    always_comb begin
        ctrlOut_next = ctrlOutPins;
        case (route)
            FWPC_ROUTE_FIFO: begin
                ctrlOut_next[0] = flagPin_next[0];
                ctrlOut_next[1] = flagPin_next[1];
                ctrlOut_next[2] = flagPin_next[2];
                ctrlOut_next[FWPC_NUM_CTRL-1:3] = waveformCtrl[FWPC_NUM_CTRL-1:3];
            end
            FWPC_ROUTE_ENGINE: begin
                ctrlOut_next = waveformCtrl;
            end
            FWPC_ROUTE_PORTS: begin
                ctrlOut_next = waveformCtrl;
            end
            default: begin
                ctrlOut_next = ctrlOutPins;
            end
        endcase
    end

    // outputs change only on interface clock edges, high out of reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrlOutPins <= FWPC_CTRL_RST;
        end else if (tick) begin
            ctrlOutPins <= ctrlOut_next;
        end
    end

    // fourth request: rising edge of the active-high pin
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irqFourPrev_reg <= FWPC_SYNC_RST[FWPC_SY_IRQ4];
            irqFourReq      <= 1'b0;
        end else begin
            irqFourPrev_reg <= irqFourLevel;
            irqFourReq      <= irqFourLevel & ~irqFourPrev_reg;
        end
    end

    // fifth request: falling edge of the active-low pin
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            irqFiveNPrev_reg <= FWPC_SYNC_RST[FWPC_SY_IRQ5N];
            irqFiveReq       <= 1'b0;
        end else begin
            irqFiveNPrev_reg <= irqFiveNLevel;
            irqFiveReq       <= ~irqFiveNLevel & irqFiveNPrev_reg;
        end
    end

endmodule : fwpc_pin_config

// ==== fwpc_pin_config_assertions.sv ====
// concurrent checks on the pins of the fifo / waveform pin block
`timescale 1ns/1ps
module fwpc_pin_config_assertions
    import fwpc_pkg::*;
(
    input wire logic                      clock,
    input wire logic                      rst_n,
    input wire logic [7:0]                interfaceConfig,
    input wire logic [FWPC_NUM_CTRL-1:0]  ctrlOutPins,
    input wire logic                      interfaceClockOe,
    input wire logic                      extIrqFour,
    input wire logic                      extIrqFiveN,
    input wire logic [FWPC_NUM_FIFOS-1:0] fifoProgLevel,
    input wire logic [FWPC_NUM_FIFOS-1:0] fifoFull,
    input wire logic [FWPC_NUM_FIFOS-1:0] fifoEmpty,
    input wire logic [FWPC_SEL_W-1:0]     fifoSelect,
    input wire logic                      fifoReadPulse,
    input wire logic                      fifoWritePulse,
    input wire logic                      interfaceClockTick,
    input wire logic                      irqFourReq,
    input wire logic                      irqFiveReq
);
    logic fifoMode_reg;
    logic steady;

    // mode seen by the block at the last edge, and held since
    always_ff @(posedge clock) fifoMode_reg <= interfaceConfig[1:0] == FWPC_MODE_FIFO;
    assign steady = fifoMode_reg && interfaceConfig[1:0] == FWPC_MODE_FIFO;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    // pin edges held long enough to pass the filter
    sequence s_four_rise;
        $rose(extIrqFour) ##1 extIrqFour [*3];
    endsequence
    sequence s_five_fall;
        $fell(extIrqFiveN) ##1 !extIrqFiveN [*3];
    endsequence

    a_read_on_tick: assert property (
        fifoReadPulse |-> interfaceClockTick && fifoMode_reg) else $error("stray read pulse");
    a_write_on_tick: assert property (
        fifoWritePulse |-> interfaceClockTick && fifoMode_reg) else $error("stray write pulse");
    a_flags_hold: assert property (
        steady && !interfaceClockTick |-> $stable(ctrlOutPins[2:0]))
        else $error("flags moved between ticks");
    a_flag_prog: assert property (
        steady && interfaceClockTick |-> ctrlOutPins[0] == !fifoProgLevel[fifoSelect])
        else $error("level flag wrong");
    a_flag_full: assert property (
        steady && interfaceClockTick |-> ctrlOutPins[1] == !fifoFull[fifoSelect])
        else $error("full flag wrong");
    a_flag_empty: assert property (
        steady && interfaceClockTick |-> ctrlOutPins[2] == !fifoEmpty[fifoSelect])
        else $error("empty flag wrong");
    a_irq_four: assert property (
        s_four_rise |-> ##[0:4] irqFourReq) else $error("no request on rising edge");
    a_irq_five: assert property (
        s_five_fall |-> ##[0:4] irqFiveReq) else $error("no request on falling edge");
    a_clock_drive: assert property (
        (interfaceConfig[7] && interfaceConfig[6]) [*3] |-> interfaceClockOe)
        else $error("clock pin not driven");
    a_tick_pulse: assert property (
        interfaceClockTick |=> !interfaceClockTick) else $error("tick longer than a cycle");
endmodule : fwpc_pin_config_assertions

bind fwpc_pin_config fwpc_pin_config_assertions i_fwpc_pin_config_assertions (
    .clock, .rst_n, .interfaceConfig, .ctrlOutPins, .interfaceClockOe, .extIrqFour,
    .extIrqFiveN, .fifoProgLevel, .fifoFull, .fifoEmpty, .fifoSelect, .fifoReadPulse,
    .fifoWritePulse, .interfaceClockTick, .irqFourReq, .irqFiveReq
);

// ==== fwpc_fifo_master.sv ====
// behavioural external fifo master: interface clock, strobes, address
`timescale 1ns/1ps
module fwpc_fifo_master (
    output logic       interface_clock,
    output logic       rdPin,
    output logic       wrPin,
    output logic [1:0] selPins
);
    // idle: clock still and low, strobes high
    initial begin
        interface_clock = 1'b0;
        rdPin = 1'b1;
        wrPin = 1'b1;
        selPins = 2'h0;
    end

    // strobe levels while the block makes its own clock
    task automatic strobe(input logic rd, input logic wr);
        #1;
        rdPin = rd;
        wrPin = wr;
    endtask : strobe

    // one frame of n clock periods, strobes held across all of them
    task automatic burst(input int n, input logic rd, input logic wr, input logic [1:0] sel,
                         input logic rh, input logic wh, input int half);
        #3;
        selPins = sel;
        rdPin = rd ~^ rh;
        wrPin = wr ~^ wh;
        #160;
        repeat (n) begin
            interface_clock = 1'b1;
            #half;
            interface_clock = 1'b0;
            #half;
        end
        #160;
        rdPin = !rh;
        wrPin = !wh;
    endtask : burst
endmodule : fwpc_fifo_master

// ==== fwpc_pin_config_tb_top.sv ====
// self-checking testbench for the fifo / waveform pin block
`timescale 1ns/1ps
module fwpc_pin_config_tb_top
    import fwpc_pkg::*;
;
    logic       clock = 1'b0;
    logic       rst_n = 1'b0;
    logic [7:0] cfg = 8'h00;
    logic [7:0] pol = 8'h00;
    logic [3:0] rdyHi = 4'h0;
    logic       irq4 = 1'b0;
    logic       irq5n = 1'b1;
    logic [5:0] wCtrl = 6'h00;
    logic [3:0] fProg = 4'h0;
    logic [3:0] fFull = 4'h0;
    logic [3:0] fEmpty = 4'h0;
    logic       interface_clock, ifPin, rdPin, wrPin, clkOut, clkOe, rdP, wrP, tick, i4, i5;
    logic [1:0] selPins, fSel;
    logic [5:0] ctrl, ready;
    logic [5:0] events;
    int         cnt[6];
    int         base[6];
    int         nErrors = 0;
    int         comparisons = 0;

    always #10 clock = ~clock;

    // clock pin level from both drivers
    assign ifPin = clkOe ? clkOut : interface_clock;

    fwpc_pin_config i_fwpc_pin_config (
        .clock, .rst_n, .interfaceConfig(cfg), .fifoPinPolarity(pol),
        .readyInPins({rdyHi, wrPin, rdPin}), .ctrlOutPins(ctrl), .fifoSelectPins(selPins),
        .interfaceClockIn(ifPin), .interfaceClockOut(clkOut), .interfaceClockOe(clkOe),
        .extIrqFour(irq4), .extIrqFiveN(irq5n), .waveformCtrl(wCtrl), .waveformReady(ready),
        .fifoProgLevel(fProg), .fifoFull(fFull), .fifoEmpty(fEmpty), .fifoSelect(fSel),
        .fifoReadPulse(rdP), .fifoWritePulse(wrP), .interfaceClockTick(tick),
        .irqFourReq(i4), .irqFiveReq(i5)
    );

    fwpc_fifo_master i_fwpc_fifo_master (.interface_clock, .rdPin, .wrPin, .selPins);

    // count one-cycle events (read, write, tick, irq four, irq five) and clock pin high cycles
    assign events = {clkOut, i5, i4, tick, wrP, rdP};
    always @(posedge clock) begin
        foreach (cnt[k]) if (events[k] === 1'b1) cnt[k] <= cnt[k] + 1;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock);
    endtask : wait_clk

    // pin flags are low while the condition holds
    function automatic logic [2:0] flags(input logic [1:0] s);
        return ~{fEmpty[s], fFull[s], fProg[s]};
    endfunction : flags

    task automatic reset_dut();
        rst_n <= 1'b0;
        wait_clk(4);
        #1;
        check(ctrl, FWPC_CTRL_RST);
        check(clkOe, 0);
        @(posedge clock);
        rst_n <= 1'b1;
    endtask : reset_dut

    // one external frame in a random mode, polarity and clock sense
    task automatic frame(input int i);
        logic [1:0] md, s;
        logic       rd, wr, inv, rh, wh, fifo;
        int         n, half;
        @(posedge clock);
        md = ($urandom_range(3) == 0) ? FWPC_MODE_WAVEFORM : FWPC_MODE_FIFO;
        if (i == 1) md = FWPC_MODE_PORTS;
        if (i == 2) md = FWPC_MODE_RESERVED;
        n = (i == 0) ? 1 : $urandom_range(6, 1);
        half = 80; // link clock period of 160 ns
        {rd, wr, inv, rh, wh, s} = 7'($urandom);
        fifo = md == FWPC_MODE_FIFO;
        cfg <= {3'h0, inv, 2'h0, md};
        pol <= {4'h0, rh, wh, 2'h0};
        fProg <= 4'($urandom);
        fFull <= 4'($urandom);
        fEmpty <= 4'($urandom);
        wCtrl <= 6'($urandom);
        rdyHi <= 4'($urandom);
        wait_clk(12);
        base = cnt;
        i_fwpc_fifo_master.burst(n, rd, wr, s, rh, wh, half);
        wait_clk(12);
        check(cnt[2] - base[2], n);
        check(cnt[0] - base[0], (fifo && rd) ? n : 0);
        check(cnt[1] - base[1], (fifo && wr) ? n : 0);
        if (fifo) begin
            check(fSel, s);
            check(ctrl, {wCtrl[5:3], flags(s)});
            check(ready, {rdyHi, 2'h0});
        end else begin
            check(ctrl, wCtrl);
            check(ready, {rdyHi, ~wh, ~rh});
        end
    endtask : frame

    // block drives the clock pin at either rate, strobes held active low
    task automatic internal(input logic fast);
        int d;
        int e;
        @(posedge clock);
        cfg <= {2'h3, fast, 3'h0, FWPC_MODE_FIFO};
        pol <= 8'h00;
        i_fwpc_fifo_master.strobe(1'b0, 1'b0);
        wait_clk(10);
        check(clkOe, 1);
        base = cnt;
        wait_clk(40);
        d = cnt[2] - base[2];
        e = fast ? 20 : 10;
        check(d >= e - 1 && d <= e + 1, 1);
        check(cnt[5] - base[5] >= 19 && cnt[5] - base[5] <= 21, 1);
        check(cnt[0] - base[0], d);
        check(cnt[1] - base[1], d);
        cfg <= {6'h00, FWPC_MODE_FIFO};
        wait_clk(10);
    endtask : internal

    // one high pulse on the fourth request pin, one low on the fifth
    task automatic irq_pulse();
        @(posedge clock);
        base = cnt;
        irq4 <= 1'b1;
        irq5n <= 1'b0;
        wait_clk(6 + $urandom_range(4));
        irq4 <= 1'b0;
        irq5n <= 1'b1;
        wait_clk(12);
        check(cnt[3] - base[3], 1);
        check(cnt[4] - base[4], 1);
    endtask : irq_pulse

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, nErrors);
        if (nErrors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // main sequence, with a reset in mid-run
    initial begin
        void'($urandom(42276));
        reset_dut();
        for (int i = 0; i < 12; i++) frame(i);
        internal(1'b1);
        internal(1'b0);
        irq_pulse();
        reset_dut();
        frame(0);
        irq_pulse();
        conclude();
    end

    // cut a hang short
    initial begin
        #1000000;
        nErrors++;
        conclude();
    end
endmodule : fwpc_pin_config_tb_top
